/* fia_cfg.svh */
// Purpose: Addresses, bit fields and reset values of the flash update regs
// Assumes: 8-bit data memory, 16-bit program words
// Notes:   Definitions only
`ifndef FIA_CFG_SVH
`define FIA_CFG_SVH

// ----------------------------------------
// Control register placement
// ----------------------------------------
`define FIA_FC_SECTOR 8'h01
`define FIA_FC0_ADDR 8'h28
`define FIA_FC1_ADDR 8'h29
`define FIA_FC2_ADDR 8'h2A
`define FIA_FC0_RESET 8'h70
`define FIA_CHIP_RST_KEY 8'h55
`define FIA_FC0_WFS 7
`define FIA_FC0_OP_MSB 6
`define FIA_FC0_OP_LSB 4
`define FIA_FC0_WPEN 3
`define FIA_FC0_FWT 2
`define FIA_FC0_FRDEN 1
`define FIA_FC0_FRD 0
`define FIA_FC2_WRITE_BUFFER_CLEAR 0

// ----------------------------------------
// Address and data registers, all sectors
// ----------------------------------------
`define FIA_DREG_BASE 8'h43
`define FIA_DREG_NUM 10
`define FIA_DREG_FLASH_WORD0_LOW 2
`define FIA_DREG_FLASH_WORD0_HIGH 3
`define FIA_DREG_FLASH_TARGET_ADDR_LOW 0
`define FIA_DREG_FLASH_TARGET_ADDR_HIGH 1

// ----------------------------------------
// Mode field codes
// ----------------------------------------
`define FIA_OP_WRITE 3'h0
`define FIA_OP_ERASE 3'h1
`define FIA_OP_READ 3'h2
`define FIA_OP_WEN 3'h6

// ----------------------------------------
// Page geometry
// ----------------------------------------
`define FIA_WORDS_LAST 5'h1F
`define FIA_PAGE_MSB 15
`define FIA_PAGE_LSB 5

`endif

/* fia_chk_props.sv */
// Purpose: Port assertions of fia_ctrl
// Assumes: One clock, async low reset
// Notes:   Bind at the foot
`timescale 1ns/1ps
module fia_chk
    import fia_pkg::*;
(
    input logic I_MCLK,
    input logic I_RST_N,
    input logic I_WR,
    input logic I_RD,
    input logic I_IND,
    input logic [7:0] I_SECTOR,
    input logic [7:0] I_ADDR,
    input logic [7:0] I_WDATA,
    input logic [7:0] O_RDATA,
    input logic [15:0] O_FL_ADDR,
    input logic O_FL_WE,
    input logic O_FL_ERASE,
    input logic O_FL_RD,
    input logic O_CHIP_RST
);
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RST_N);
    // Only the indirect sector 1 path may hit the key
    logic key_w;
    assign key_w = I_WR && I_IND && I_SECTOR == 8'h01 && I_ADDR == 8'h29
        && I_WDATA == 8'h55;
    key_reset_a: assert property (key_w |=> O_CHIP_RST)
        else $error("chip reset missing");
    reset_cause_a: assert property (O_CHIP_RST |-> $past(key_w))
        else $error("chip reset without key");
    direct_hidden_a: assert property (I_RD && !I_IND && I_ADDR == 8'h28
        |=> O_RDATA == 8'h00) else $error("direct read seen");
    sector_hidden_a: assert property (I_RD && I_IND && I_ADDR == 8'h28
        && I_SECTOR != 8'h01 |=> O_RDATA == 8'h00) else $error("sector read");
    any_sector_a: assert property (I_WR && I_ADDR == 8'h43 ##1 I_RD
        && I_ADDR == 8'h43 |=> O_RDATA == $past(I_WDATA, 2))
        else $error("addr reg readback");
    rd_pulse_a: assert property (O_FL_RD |=> !O_FL_RD)
        else $error("read pulse long");
    erase_pulse_a: assert property (O_FL_ERASE |=> !O_FL_ERASE [*2])
        else $error("erase pulse long");
    burst_step_a: assert property (O_FL_WE && O_FL_ADDR[4:0] != 5'h1F
        |=> !O_FL_WE ##1 O_FL_WE
        && O_FL_ADDR[4:0] == $past(O_FL_ADDR[4:0], 2) + 5'h01)
        else $error("burst step");
endmodule : fia_chk
bind fia_ctrl fia_chk chk (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N),
    .I_WR(I_WR), .I_RD(I_RD), .I_IND(I_IND), .I_SECTOR(I_SECTOR),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA),
    .O_FL_ADDR(O_FL_ADDR), .O_FL_WE(O_FL_WE), .O_FL_ERASE(O_FL_ERASE),
    .O_FL_RD(O_FL_RD), .O_CHIP_RST(O_CHIP_RST));

/* fia_ctrl.sv */
// Purpose: In-app flash update register front end and sequencer
// Assumes: CPU data memory port on I_MCLK; flash macro answers on I_MCLK
// Notes:   Word pushes into the write buffer on each data high byte write, except during the clear walk
`timescale 1ns/1ps
`include "fia_cfg.svh"

module fia_ctrl
    import fia_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic I_IND,
    input wire logic [7:0] I_SECTOR,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    output logic [7:0] O_RDATA,
    output logic [15:0] O_FL_ADDR,
    output logic [15:0] O_FL_WDATA,
    output logic O_FL_WE,
    output logic O_FL_ERASE,
    output logic O_FL_RD,
    input wire logic I_FL_DONE,
    input wire logic [15:0] I_FL_RDATA,
    output logic O_CHIP_RST
);

    typedef struct packed {
        fia_st_type st;
        logic wfs;
        logic [2:0] op;
        logic wpen;
        logic fwt;
        logic frden;
        logic frd;
        logic [7:0] fc1;
        logic write_buffer_clear;
        logic [`FIA_DREG_NUM-1:0][7:0] dreg;
        logic [4:0] wptr;
        logic [4:0] idx;
        logic [7:0] rdata;
        logic [15:0] fl_addr;
        logic [15:0] fl_wdata;
        logic fl_we;
        logic fl_erase;
        logic fl_rd;
        logic chip_rst;
    } fia_ctrl_type;

    fia_ctrl_type s_r;
    fia_ctrl_type s_nxt;

    logic fc_hit;
    logic wb_we;
    logic [4:0] wb_waddr;
    logic [15:0] wb_wdata;
    logic [4:0] wb_raddr;
    logic [15:0] wb_rdata;
    logic [15:0] far;
    logic fc0_wr;
    logic fc2_wr;

    // ----------------------------------------
    // Write buffer
    // ----------------------------------------
    fia_wbuf u_wbuf (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_we(wb_we),
        .i_waddr(wb_waddr),
        .i_wdata(wb_wdata),
        .i_raddr(wb_raddr),
        .o_rdata(wb_rdata)
    );

    // Direct access never sees the control regs, whatever the sector
    assign fc_hit = I_IND && (I_SECTOR == `FIA_FC_SECTOR);
    assign far = {s_r.dreg[`FIA_DREG_FLASH_TARGET_ADDR_HIGH], s_r.dreg[`FIA_DREG_FLASH_TARGET_ADDR_LOW]};
    assign fc0_wr = I_WR && fc_hit && I_ADDR == `FIA_FC0_ADDR;
    assign fc2_wr = I_WR && fc_hit && I_ADDR == `FIA_FC2_ADDR;
    assign wb_raddr = s_r.idx;

    // ----------------------------------------
    // Register access and sequencer
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.fl_we = 1'b0;
        s_nxt.fl_erase = 1'b0;
        s_nxt.fl_rd = 1'b0;
        s_nxt.chip_rst = 1'b0;
        wb_we = 1'b0;
        wb_waddr = s_r.wptr;
        wb_wdata = '0;

        // Software writes first; hardware clears below keep a fresh set
        if (fc0_wr) begin
            s_nxt.wfs = s_r.wfs & I_WDATA[`FIA_FC0_WFS];
            s_nxt.op = I_WDATA[`FIA_FC0_OP_MSB:`FIA_FC0_OP_LSB];
            s_nxt.wpen = I_WDATA[`FIA_FC0_WPEN];
            s_nxt.fwt = I_WDATA[`FIA_FC0_FWT];
            s_nxt.frden = I_WDATA[`FIA_FC0_FRDEN];
            s_nxt.frd = I_WDATA[`FIA_FC0_FRD];
        end
        if (I_WR && fc_hit && I_ADDR == `FIA_FC1_ADDR) begin
            s_nxt.fc1 = I_WDATA;
            s_nxt.chip_rst = (I_WDATA == `FIA_CHIP_RST_KEY);
        end
        if (fc2_wr) begin
            s_nxt.write_buffer_clear = I_WDATA[`FIA_FC2_WRITE_BUFFER_CLEAR];
        end
        for (int i = 0; i < `FIA_DREG_NUM; i++) begin
            if (I_WR && I_ADDR == `FIA_DREG_BASE + 8'(i)) begin
                s_nxt.dreg[i] = I_WDATA;
                // A high data byte completes one buffered word
                if (i >= `FIA_DREG_FLASH_WORD0_HIGH && (i % 2) == 1) begin
                    wb_we = 1'b1;
                    wb_wdata = {I_WDATA, s_r.dreg[i-1]};
                    s_nxt.wptr = s_r.wptr + 5'h01;
                end
            end
        end

        // Read data, registered
        s_nxt.rdata = s_r.rdata;
        if (I_RD) begin
            s_nxt.rdata = '0;
            if (fc_hit && I_ADDR == `FIA_FC0_ADDR) begin
                s_nxt.rdata = {s_r.wfs, s_r.op, s_r.wpen, s_r.fwt,
                               s_r.frden, s_r.frd};
            end
            if (fc_hit && I_ADDR == `FIA_FC1_ADDR) begin
                s_nxt.rdata = s_r.fc1;
            end
            if (fc_hit && I_ADDR == `FIA_FC2_ADDR) begin
                s_nxt.rdata = {7'h00, s_r.write_buffer_clear};
            end
            for (int i = 0; i < `FIA_DREG_NUM; i++) begin
                if (I_ADDR == `FIA_DREG_BASE + 8'(i)) begin
                    s_nxt.rdata = s_r.dreg[i];
                end
            end
        end

        unique case (s_r.st)
            S_IDLE: begin
                s_nxt.idx = '0;
                if (s_r.write_buffer_clear) begin
                    s_nxt.st = S_CLR;
                end else if (s_r.wpen) begin
                    s_nxt.wpen = s_nxt.wpen && fc0_wr;
                    if (s_r.op == `FIA_OP_WEN) begin
                        s_nxt.wfs = 1'b1;
                    end
                end else if (s_r.fwt) begin
                    s_nxt.fl_addr = far;
                    if (s_r.op == `FIA_OP_WRITE && s_r.wfs) begin
                        s_nxt.st = S_WRRD;
                    end else if (s_r.op == `FIA_OP_ERASE && s_r.wfs) begin
                        s_nxt.fl_erase = 1'b1;
                        s_nxt.st = S_WAIT;
                    end else begin
                        // Writing disabled: request dropped
                        s_nxt.fwt = s_nxt.fwt && fc0_wr;
                    end
                end else if (s_r.frd) begin
                    s_nxt.fl_addr = far;
                    if (s_r.frden && s_r.op == `FIA_OP_READ) begin
                        s_nxt.fl_rd = 1'b1;
                        s_nxt.st = S_RDWAIT;
                    end else begin
                        s_nxt.frd = s_nxt.frd && fc0_wr;
                    end
                end
            end
            S_CLR: begin
                // Clear walk owns the buffer write port
                wb_we = 1'b1;
                wb_waddr = s_r.idx;
                wb_wdata = '0;
                s_nxt.idx = s_r.idx + 5'h01;
                if (s_r.idx == `FIA_WORDS_LAST) begin
                    s_nxt.write_buffer_clear = s_nxt.write_buffer_clear && fc2_wr;
                    s_nxt.wptr = '0;
                    s_nxt.st = S_IDLE;
                end
            end
            S_WRRD: begin
                s_nxt.st = S_WRPUT;
            end
            S_WRPUT: begin
                s_nxt.fl_we = 1'b1;
                s_nxt.fl_wdata = wb_rdata;
                s_nxt.fl_addr = {far[`FIA_PAGE_MSB:`FIA_PAGE_LSB], s_r.idx};
                s_nxt.idx = s_r.idx + 5'h01;
                s_nxt.st = (s_r.idx == `FIA_WORDS_LAST) ? S_WAIT : S_WRRD;
            end
            S_WAIT: begin
                if (I_FL_DONE) begin
                    s_nxt.fwt = s_nxt.fwt && fc0_wr;
                    s_nxt.st = S_IDLE;
                end
            end
            S_RDWAIT: begin
                if (I_FL_DONE) begin
                    s_nxt.dreg[`FIA_DREG_FLASH_WORD0_LOW] = I_FL_RDATA[7:0];
                    s_nxt.dreg[`FIA_DREG_FLASH_WORD0_HIGH] = I_FL_RDATA[15:8];
                    s_nxt.frd = s_nxt.frd && fc0_wr;
                    s_nxt.st = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            s_r <= '0;
            s_r.st <= S_IDLE;
            {s_r.wfs, s_r.op, s_r.wpen, s_r.fwt, s_r.frden, s_r.frd}
                <= `FIA_FC0_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign O_RDATA = s_r.rdata;
    assign O_FL_ADDR = s_r.fl_addr;
    assign O_FL_WDATA = s_r.fl_wdata;
    assign O_FL_WE = s_r.fl_we;
    assign O_FL_ERASE = s_r.fl_erase;
    assign O_FL_RD = s_r.fl_rd;
    assign O_CHIP_RST = s_r.chip_rst;

endmodule : fia_ctrl

/* fia_ctrl_tb.sv */
// Purpose: Self-checking bench of fia_ctrl
// Assumes: Bench plays CPU and flash macro
// Notes:   Inputs change at falling edges
`timescale 1ns/1ps
module fia_ctrl_tb
    import fia_pkg::*;
;
    logic mclk = 0, rst_n = 0, wr = 0, rd = 0, ind = 0, fl_done = 0;
    logic fl_we, fl_erase, fl_rd, chip_rst;
    logic [7:0] sec = 8'h00, addr = 8'h00, wdata = 8'h00, rdata;
    logic [15:0] far = 16'h1FE5, fl_rdata = 16'hC3A5, fl_addr, fl_wdata;
    int miscompares = 0, samples_checked = 0, k, n;
    always #20 mclk = ~mclk;
    fia_ctrl uut (.I_MCLK(mclk), .I_RST_N(rst_n), .I_WR(wr), .I_RD(rd),
        .I_IND(ind), .I_SECTOR(sec), .I_ADDR(addr), .I_WDATA(wdata),
        .O_RDATA(rdata), .O_FL_ADDR(fl_addr), .O_FL_WDATA(fl_wdata),
        .O_FL_WE(fl_we), .O_FL_ERASE(fl_erase), .O_FL_RD(fl_rd),
        .I_FL_DONE(fl_done), .I_FL_RDATA(fl_rdata), .O_CHIP_RST(chip_rst));
    task automatic check(input string what, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // Strobes drop before the next access: no doubled writes
    task automatic acc(input logic w, i, input logic [7:0] s, a, d);
        @(negedge mclk);
        {wr, rd, ind, sec, addr, wdata} = {w, !w, i, s, a, d};
        @(negedge mclk);
        {wr, rd} = 2'b00;
    endtask : acc
    task automatic rchk(input logic i, input logic [7:0] s, a, e);
        acc(0, i, s, a, 8'h00);
        check($sformatf("reg %h", a), rdata, e);
    endtask : rchk
    task automatic op(input logic [7:0] cmd, fin, input int nwe);
        n = 0;
        acc(1, 1, 8'h01, 8'h28, cmd);
        for (k = 0; k < 300; k++) begin
            @(negedge mclk);
            if (fl_we) begin
                check("word addr", fl_addr, {far[15:5], n[4:0]});
                check("word", fl_wdata, n == 0 ? 16'h1234 : 16'h0000);
                n++;
            end
            if (fl_rd || fl_erase || n == 32)
                break;
        end
        if (k == 300) begin
            miscompares++;
            conclude();
        end
        check("page", fl_addr[15:5], far[15:5]);
        check("words", n[15:0], nwe[15:0]);
        repeat (2) @(negedge mclk);
        fl_done = 1;
        @(negedge mclk);
        fl_done = 0;
        repeat (3) @(negedge mclk);
        rchk(1, 8'h01, 8'h28, fin);
    endtask : op
    initial begin
        repeat (3) @(negedge mclk);
        rst_n = 1;
        rchk(1, 8'h01, 8'h28, 8'h70);
        rchk(0, 8'h01, 8'h28, 8'h00);
        rchk(1, 8'h02, 8'h28, 8'h00);
        @(negedge mclk);
        {wr, sec, addr, wdata} = {1'b1, 8'h07, 8'h43, far[7:0]};
        @(negedge mclk);
        {wr, rd} = 2'b01;
        @(negedge mclk);
        rd = 0;
        check("far low", rdata, far[7:0]);
        acc(1, 0, 8'h00, 8'h44, far[15:8]);
        acc(1, 1, 8'h01, 8'h28, 8'hF0);
        rchk(1, 8'h01, 8'h28, 8'h70);
        acc(1, 1, 8'h01, 8'h28, 8'h68);
        repeat (2) @(negedge mclk);
        rchk(1, 8'h01, 8'h28, 8'hE0);
        acc(1, 1, 8'h01, 8'h2A, 8'h01);
        rchk(1, 8'h01, 8'h2A, 8'h01);
        for (k = 0; k < 40 && rdata !== 8'h00; k++)
            acc(0, 1, 8'h01, 8'h2A, 8'h00);
        check("clear time", k >= 15 && k <= 17, 1'b1);
        if (k == 40)
            conclude();
        acc(1, 0, 8'h03, 8'h45, 8'h34);
        acc(1, 0, 8'h03, 8'h46, 8'h12);
        op(8'h84, 8'h80, 32);
        op(8'h94, 8'h90, 0);
        op(8'hA3, 8'hA2, 0);
        check("read addr", fl_addr, far);
        rchk(0, 8'h05, 8'h45, fl_rdata[7:0]);
        rchk(0, 8'h05, 8'h46, fl_rdata[15:8]);
        acc(1, 1, 8'h01, 8'h28, 8'h04);
        repeat (8) begin
            @(negedge mclk);
            check("refused", {fl_we, fl_erase}, 2'b00);
        end
        rchk(1, 8'h01, 8'h28, 8'h00);
        acc(1, 1, 8'h01, 8'h28, 8'h21);
        repeat (4) begin
            @(negedge mclk);
            check("read refused", fl_rd, 1'b0);
        end
        rchk(1, 8'h01, 8'h28, 8'h20);
        acc(1, 0, 8'h00, 8'h29, 8'h55);
        check("no direct reset", chip_rst, 1'b0);
        acc(1, 1, 8'h01, 8'h29, 8'h55);
        check("chip reset", chip_rst, 1'b1);
        @(negedge mclk);
        check("reset pulse", chip_rst, 1'b0);
        repeat (2) @(negedge mclk);
        conclude();
    end
endmodule : fia_ctrl_tb

/* fia_pkg.sv */
// Purpose: Types of the flash update front end
// Assumes: fia_cfg.svh holds the numbers
// Notes:   Types only
package fia_pkg;

    typedef enum logic [2:0] {
        S_IDLE,
        S_CLR,
        S_WRRD,
        S_WRPUT,
        S_WAIT,
        S_RDWAIT
    } fia_st_type;

endpackage : fia_pkg

/* fia_wbuf.sv */
// Purpose: 32-word write buffer of the flash update front end
// Assumes: One write and one read port, same clock
// Notes:   Read data is registered, one cycle after the address
`timescale 1ns/1ps
`include "fia_cfg.svh"

module fia_wbuf
    import fia_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_we,
    input wire logic [4:0] i_waddr,
    input wire logic [15:0] i_wdata,
    input wire logic [4:0] i_raddr,
    output logic [15:0] o_rdata
);

    typedef struct packed {
        logic [31:0][15:0] mem;
        logic [15:0] rdata;
    } fia_wbuf_type;

    fia_wbuf_type s_r;
    fia_wbuf_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = s_r.mem[i_raddr];
        if (i_we) begin
            s_nxt.mem[i_waddr] = i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata = s_r.rdata;

endmodule : fia_wbuf
